// [logic/pwr_mode_consts.vh]
`ifndef PWR_MODE_CONSTS_VH
`define PWR_MODE_CONSTS_VH
// Register byte offsets
`define OFS_SENSE        8'h00
`define OFS_TOP          8'h04
`define OFS_CLK          8'h08
`define OFS_STATUS       8'h0C
// Field positions
`define TOP_EN_BIT       0
`define TOP_EDGE_BIT     1
`define CLK_SLOW_BIT     0
`define CLK_DIV_LSB      1
`define CLK_OSC_IRQ_BIT  3
`define CLK_AWU_BIT      4
`define CLK_LONGSTART_BIT 5
// Reset values
`define SENSE_RST        8'h00
`define TOP_RST          8'h00
`define CLK_RST          8'h00
// Sensitivity codes
`define SENS_FALL_LOW    2'b00
`define SENS_RISE        2'b01
`define SENS_FALL        2'b10
`define SENS_BOTH        2'b11
// Mask levels
`define MASK_ENABLED     2'b10
`define MASK_LEVEL3      2'b11
// Oscillator start-up delays in CPU cycles
`define START_SHORT      13'd256
`define START_LONG       13'd4096
// AXI responses
`define RESP_OKAY        2'b00
`define RESP_SLVERR      2'b10
`endif

// [logic/power_mode_and_ext_wake_ctrl.v]
// Functional notes
// - Reset selects run mode, master clock
// - Slow mode divides master clock 2..16
// - Wait in slow mode keeps slow clock
// - Wait stops core clock, peripherals run
// - Wait forces mask bits to 10
// - Wait ends on interrupt or reset
// - Halt only if osc-irq and auto-wake clear
// - Halt exit waits 256 or 4096 cycles
// - Halt forces mask 10, pending wakes immediately
// - Halt stops oscillator and all clocks
// - Watchdog-in-halt option turns halt into reset
// - Service pushes mask, loads software priority
// - Four two-bit sensitivity fields and codes
// - Sensitivity writable only at mask level 3
// - Changed sensitivity clears group pending
// - Top edge select writable only when disabled
// - Top enable bit freely read and written
// - Clearing top enable may raise spurious request
// - Both interrupt control registers reset zero
// - Top, trap, reset service set mask 11
//
// Decided for this implementation: the register offsets and register access over AXI4-Lite.

`timescale 1ns/10ps
`include "pwr_mode_consts.vh"
module power_mode_and_ext_wake_ctrl
(
    input  wire        core_clk_i,
    input  wire        arst_n_i,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire [3:0]  ext_line_group_i,
    input  wire        top_level_interrupt_i,
    input  wire        wait_instr_i,
    input  wire        halt_instr_i,
    input  wire        watchdog_enabled_i,
    input  wire        watchdog_in_halt_option_i,
    input  wire [1:0]  cpu_mask_i,
    input  wire        irq_service_i,
    input  wire        nmi_service_i,
    input  wire [1:0]  sw_priority_i,
    input  wire        wake_irq_i,
    output reg  [1:0]  mask_force_val_o,
    output reg         mask_force_o,
    output reg         mask_push_o,
    output reg         core_clk_en_o,
    output reg         periph_clk_en_o,
    output reg         osc_on_o,
    output reg         watchdog_reset_o,
    output reg  [3:0]  ext_pending_o,
    output reg         top_pending_o,
    output reg  [2:0]  mode_o
);
// ==========================================================
// Modes and helpers
// Mode codes double as the mode_o encoding seen by software
localparam [2:0] ST_RUN   = 3'd0;
localparam [2:0] ST_WAIT  = 3'd1;
localparam [2:0] ST_HALT  = 3'd2;
localparam [2:0] ST_START = 3'd3;

// One sensitivity decode shared by all four groups
function edge_hit;
    input [1:0] code;
    input       prev;
    input       cur;
    begin
        case (code)
            `SENS_FALL_LOW: edge_hit = ~cur;
            `SENS_RISE:     edge_hit = ~prev & cur;
            `SENS_FALL:     edge_hit = prev & ~cur;
            default:        edge_hit = prev ^ cur;
        endcase
    end
endfunction

// ==========================================================
// Pin synchronisers
// Lines idle high; ext stages reset high so no false fall follows reset, top stages reset low
reg [3:0] ext_s1_r;
reg [3:0] ext_s2_r;
reg [3:0] ext_prev_r;
// Only s2 and prev feed logic; s1 may be metastable
reg       top_s1_r;
reg       top_s2_r;
reg       top_prev_r;

always @(posedge core_clk_i or negedge arst_n_i)
begin
    if (!arst_n_i)
    begin
        ext_s1_r   <= 4'hF;
        ext_s2_r   <= 4'hF;
        ext_prev_r <= 4'hF;
        top_s1_r   <= 1'b0;
        top_s2_r   <= 1'b0;
        top_prev_r <= 1'b0;
    end
    else
    begin
        ext_s1_r   <= ext_line_group_i;
        ext_s2_r   <= ext_s1_r;
        ext_prev_r <= ext_s2_r;
        top_s1_r   <= top_level_interrupt_i;
        top_s2_r   <= top_s1_r;
        top_prev_r <= top_s2_r;
    end
end

// ==========================================================
// Registers and AXI4-Lite write channel
reg [7:0] sense_r;
reg [7:0] top_r;
reg [7:0] clk_r;
reg [7:0] aw_addr_r;
reg [31:0] w_data_r;
reg [3:0]  w_strb_r;
// Address and data may come in either order; each is parked until both are in
reg        aw_got_r;
reg        w_got_r;
reg [2:0]  state_r;
reg [12:0] cnt_r;

// Sensitivity fields move only at mask level 3; other writes are dropped
wire       level3     = (cpu_mask_i == `MASK_LEVEL3);
wire       do_write   = aw_got_r & w_got_r & ~s_axi_bvalid;
wire       wr_sense   = do_write & (aw_addr_r == `OFS_SENSE) & w_strb_r[0];
wire       wr_top     = do_write & (aw_addr_r == `OFS_TOP) & w_strb_r[0];
wire       wr_clk     = do_write & (aw_addr_r == `OFS_CLK) & w_strb_r[0];
wire       addr_ok_w  = (aw_addr_r == `OFS_SENSE) | (aw_addr_r == `OFS_TOP) |
                        (aw_addr_r == `OFS_CLK) | (aw_addr_r == `OFS_STATUS);
wire [7:0] sense_nxt  = (wr_sense & level3) ? w_data_r[7:0] : sense_r;
// Edge select is frozen while the top input is enabled
wire       top_edge_nxt = (wr_top & ~top_r[`TOP_EN_BIT]) ?
                          w_data_r[`TOP_EDGE_BIT] : top_r[`TOP_EDGE_BIT];
wire       top_en_nxt = wr_top ? w_data_r[`TOP_EN_BIT] : top_r[`TOP_EN_BIT];

// Per-group change flags; a changed field drops that group's pending
reg  [3:0] grp_changed;
integer    g;
always @*
begin
    grp_changed = 4'h0;
    for (g = 0; g < 4; g = g + 1)
        grp_changed[g] = (sense_nxt[2*g +: 2] != sense_r[2*g +: 2]);
end

// One write in flight; the response follows both halves
always @(posedge core_clk_i or negedge arst_n_i)
begin
    if (!arst_n_i)
    begin
        s_axi_awready <= 1'b0;
        s_axi_wready  <= 1'b0;
        s_axi_bvalid  <= 1'b0;
        s_axi_bresp   <= `RESP_OKAY;
        aw_got_r      <= 1'b0;
        w_got_r       <= 1'b0;
        aw_addr_r     <= 8'h00;
        w_data_r      <= 32'h0000_0000;
        w_strb_r      <= 4'h0;
        sense_r       <= `SENSE_RST;
        top_r         <= `TOP_RST;
        clk_r         <= `CLK_RST;
    end
    else
    begin
        s_axi_awready <= ~aw_got_r & ~s_axi_awready & s_axi_awvalid;
        s_axi_wready  <= ~w_got_r & ~s_axi_wready & s_axi_wvalid;
        if (s_axi_awvalid & s_axi_awready)
        begin
            aw_got_r  <= 1'b1;
            aw_addr_r <= {s_axi_awaddr[7:2], 2'b00};
        end
        if (s_axi_wvalid & s_axi_wready)
        begin
            w_got_r  <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
        end
        if (do_write)
        begin
            s_axi_bvalid <= 1'b1;
            // Writes outside the map still answer, with an error code
            s_axi_bresp  <= addr_ok_w ? `RESP_OKAY : `RESP_SLVERR;
            sense_r <= sense_nxt;
            top_r   <= {6'b00_0000, top_edge_nxt, top_en_nxt};
            if (wr_clk)
                clk_r <= {2'b00, w_data_r[5:0]};
        end
        // Both halves are released only once the response is taken
        if (s_axi_bvalid & s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
            aw_got_r <= 1'b0;
            w_got_r  <= 1'b0;
        end
    end
end

// ==========================================================
// AXI4-Lite read channel
// Read data is taken from the registers at the address handshake
always @(posedge core_clk_i or negedge arst_n_i)
begin
    if (!arst_n_i)
    begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b0;
        s_axi_rdata   <= 32'h0000_0000;
        s_axi_rresp   <= `RESP_OKAY;
    end
    else
    begin
        s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
        if (s_axi_arvalid & s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `RESP_OKAY;
            case ({s_axi_araddr[7:2], 2'b00})
                `OFS_SENSE:  s_axi_rdata <= {24'h00_0000, sense_r};
                `OFS_TOP:    s_axi_rdata <= {24'h00_0000, top_r};
                `OFS_CLK:    s_axi_rdata <= {24'h00_0000, clk_r};
                // Status: mode, pending bits and force flag
                `OFS_STATUS: s_axi_rdata <= {19'h0_0000, state_r, ext_pending_o,
                                              top_pending_o, mask_force_o, 4'h0};
                // Unmapped reads return zero with an error
                default:
                begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rvalid & s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end
end

// ==========================================================
// External and top-level event detection
reg [3:0] ext_hit;
integer   k;
always @*
begin
    ext_hit = 4'h0;
    for (k = 0; k < 4; k = k + 1)
        ext_hit[k] = edge_hit(sense_r[2*k +: 2], ext_prev_r[k], ext_s2_r[k]);
end

// Top pin uses one edge only, picked by the select bit
wire top_edge = top_r[`TOP_EDGE_BIT] ? (~top_prev_r & top_s2_r)
                                     : (top_prev_r & ~top_s2_r);
// Clearing enable while the pin sits at its active level can look like an edge
wire top_spurious = wr_top & top_r[`TOP_EN_BIT] & ~w_data_r[`TOP_EN_BIT] &
                    (top_s2_r == top_r[`TOP_EDGE_BIT]);

// Group pending cleared on service or sensitivity change; new hit wins
always @(posedge core_clk_i or negedge arst_n_i)
begin
    if (!arst_n_i)
    begin
        ext_pending_o <= 4'h0;
        top_pending_o <= 1'b0;
    end
    else
    begin
        ext_pending_o <= ext_hit | (ext_pending_o & ~grp_changed &
                         {4{~irq_service_i}});
        top_pending_o <= (top_edge & top_r[`TOP_EN_BIT]) | top_spurious |
                         (top_pending_o & ~nmi_service_i);
    end
end

// ==========================================================
// Power mode sequencer
// One clock domain: core and peripheral clocks are modelled as enables
// A halt request with a wake source already pending is dropped at once
wire [4:0] slow_div = 5'd2 << clk_r[`CLK_DIV_LSB +: 2];
wire       slow_on  = clk_r[`CLK_SLOW_BIT];
wire [12:0] start_len = clk_r[`CLK_LONGSTART_BIT] ? `START_LONG : `START_SHORT;
// Divider free-runs so the slow rate keeps its phase across mode changes
reg  [4:0] div_cnt_r;
reg  [2:0] state_nxt;
wire       any_irq = wake_irq_i | (|ext_pending_o) | top_pending_o;
wire       slow_tick = ~slow_on | (div_cnt_r == 5'd0);
always @*
begin
    state_nxt = state_r;
    case (state_r)
        ST_RUN:
            if (halt_instr_i & ~clk_r[`CLK_OSC_IRQ_BIT] & ~clk_r[`CLK_AWU_BIT] &
                ~(watchdog_enabled_i & watchdog_in_halt_option_i))
                state_nxt = any_irq ? ST_RUN : ST_HALT;
            else if (wait_instr_i)
                state_nxt = ST_WAIT;
        ST_WAIT:  if (any_irq) state_nxt = ST_RUN;
        ST_HALT:  if (any_irq) state_nxt = ST_START;
        ST_START: if (cnt_r >= start_len - 13'd1) state_nxt = ST_RUN;
        default:  state_nxt = ST_RUN;
    endcase
end

// Outputs follow the next state, so mode_o always equals state_r
always @(posedge core_clk_i or negedge arst_n_i)
begin
    if (!arst_n_i)
    begin
        state_r <= ST_RUN;
        cnt_r <= 13'd0;
        div_cnt_r <= 5'd0;
        mode_o <= ST_RUN;
        core_clk_en_o <= 1'b1;
        periph_clk_en_o <= 1'b1;
        osc_on_o <= 1'b1;
        watchdog_reset_o <= 1'b0;
        mask_force_o <= 1'b0;
        mask_force_val_o <= `MASK_LEVEL3;
        mask_push_o <= 1'b0;
    end
    else
    begin
        state_r <= state_nxt;
        mode_o  <= state_nxt;
        cnt_r   <= (state_nxt == ST_START && state_r == ST_START) ?
                   cnt_r + 13'd1 : 13'd0;
        div_cnt_r <= slow_tick ? slow_div - 5'd1 : div_cnt_r - 5'd1;
        // Watchdog option wins over halt; the core sees a reset instead
        watchdog_reset_o <= (state_r == ST_RUN) & halt_instr_i &
                            watchdog_enabled_i & watchdog_in_halt_option_i;
        // Peripherals keep the slow rate in slow-wait
        periph_clk_en_o <= (state_nxt == ST_RUN || state_nxt == ST_WAIT) & slow_tick;
        core_clk_en_o   <= (state_nxt == ST_RUN) & slow_tick;
        osc_on_o        <= (state_nxt != ST_HALT);
        // Push goes out with the load so the saved level is the old one
        mask_push_o     <= irq_service_i | nmi_service_i;
        if (nmi_service_i)
        begin
            mask_force_o <= 1'b1;
            mask_force_val_o <= `MASK_LEVEL3;
        end
        else if (irq_service_i)
        begin
            mask_force_o <= 1'b1;
            mask_force_val_o <= sw_priority_i;
        end
        else if (state_nxt == ST_WAIT || state_nxt == ST_HALT ||
                 (state_r == ST_RUN && halt_instr_i))
        begin
            mask_force_o <= 1'b1;
            mask_force_val_o <= `MASK_ENABLED;
        end
        else
            mask_force_o <= 1'b0;
    end
end
endmodule // power_mode_and_ext_wake_ctrl

// [bench/power_mode_and_ext_wake_ctrl_props.sv]
`timescale 1ns/10ps
// ========
// Port checker
module power_mode_and_ext_wake_ctrl_props (
    input logic       core_clk_i,
    input logic       arst_n_i,
    input logic       s_axi_bvalid,
    input logic       s_axi_bready,
    input logic       halt_instr_i,
    input logic       wait_instr_i,
    input logic       watchdog_enabled_i,
    input logic       watchdog_in_halt_option_i,
    input logic       wake_irq_i,
    input logic       nmi_service_i,
    input logic [2:0] mode_o,
    input logic       osc_on_o,
    input logic       core_clk_en_o,
    input logic       watchdog_reset_o,
    input logic       mask_force_o,
    input logic [1:0] mask_force_val_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!arst_n_i);
    logic [12:0] st_cnt_r;
    // Length of the last start-up stretch, read on return to run
    always_ff @(posedge core_clk_i or negedge arst_n_i)
        if (!arst_n_i)
            st_cnt_r <= 13'h0000;
        else
            st_cnt_r <= (mode_o == 3'd3) ? st_cnt_r + 13'h0001 : 13'h0000;
    property p_bhold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
    endproperty
    a_bhold: assert property (p_bhold) else $error("write response dropped");
    property p_halt_off;
        mode_o == 3'd2 |-> !osc_on_o && !core_clk_en_o;
    endproperty
    a_halt_off: assert property (p_halt_off) else $error("clock alive in halt");
    property p_wait_core;
        mode_o == 3'd1 |-> !core_clk_en_o;
    endproperty
    a_wait_core: assert property (p_wait_core) else $error("core runs in wait");
    property p_wdg;
        halt_instr_i && mode_o == 3'd0 && watchdog_enabled_i && watchdog_in_halt_option_i
            |-> ##[1:2] watchdog_reset_o;
    endproperty
    a_wdg: assert property (p_wdg) else $error("no watchdog reset");
    property p_halt_wake;
        mode_o == 3'd2 && wake_irq_i |-> ##[1:4] mode_o == 3'd3;
    endproperty
    a_halt_wake: assert property (p_halt_wake) else $error("halt not left");
    property p_start;
        mode_o == 3'd0 && st_cnt_r != 13'h0000 |-> st_cnt_r == 13'h0100 || st_cnt_r == 13'h1000;
    endproperty
    a_start: assert property (p_start) else $error("bad start-up delay");
    property p_nmi;
        nmi_service_i |-> ##[1:2] mask_force_o && mask_force_val_o == 2'b11;
    endproperty
    a_nmi: assert property (p_nmi) else $error("mask not set to 11");
    property p_wait_mask;
        wait_instr_i && mode_o == 3'd0 |-> ##[0:2] mask_force_o && mask_force_val_o == 2'b10;
    endproperty
    a_wait_mask: assert property (p_wait_mask) else $error("mask not set to 10");
    c_halt: cover property (mode_o == 3'd2);
    c_wait: cover property (mode_o == 3'd1);
    c_wdg: cover property (watchdog_reset_o);
endmodule // power_mode_and_ext_wake_ctrl_props
bind power_mode_and_ext_wake_ctrl power_mode_and_ext_wake_ctrl_props i_props (.*);

// [bench/core_mask_model.sv]
`timescale 1ns/10ps
// ========
// Core mask bits
module core_mask_model (
    input  logic       clk_i,
    input  logic       arst_n_i,
    input  logic       force_i,
    input  logic [1:0] force_val_i,
    input  logic       sw_set_i,
    input  logic [1:0] sw_val_i,
    output logic [1:0] mask_o
);
    // Hardware force wins over a software load in the same cycle
    always_ff @(posedge clk_i or negedge arst_n_i)
        if (!arst_n_i)
            mask_o <= 2'b11;
        else if (force_i)
            mask_o <= force_val_i;
        else if (sw_set_i)
            mask_o <= sw_val_i;
endmodule // core_mask_model

// [bench/power_mode_and_ext_wake_ctrl_test.sv]
`timescale 1ns/10ps
`include "pwr_mode_consts.vh"
module power_mode_and_ext_wake_ctrl_test;
logic        core_clk_i, arst_n_i, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
logic        s_axi_rready, top_level_interrupt_i, wait_instr_i, halt_instr_i, osc_on_o;
logic        watchdog_enabled_i, watchdog_in_halt_option_i, irq_service_i, nmi_service_i;
logic        wake_irq_i, mask_force_o, mask_push_o, core_clk_en_o, periph_clk_en_o;
logic        watchdog_reset_o, top_pending_o, sw_set;
logic [1:0]  s_axi_bresp, s_axi_rresp, cpu_mask_i, sw_priority_i, mask_force_val_o, sw_val;
logic [1:0]  m, rd_resp, wr_resp;
logic [2:0]  mode_o;
logic [3:0]  s_axi_wstrb, ext_line_group_i, ext_pending_o;
logic [7:0]  s_axi_awaddr, s_axi_araddr, sense, topv, hc;
logic [31:0] s_axi_wdata, s_axi_rdata, rd_d, d;
int          fails = 0, n_tests = 0, cyc = 0, n;
power_mode_and_ext_wake_ctrl i_dut (.*);
core_mask_model i_core (.clk_i(core_clk_i), .arst_n_i(arst_n_i), .force_i(mask_force_o),
    .force_val_i(mask_force_val_o), .sw_set_i(sw_set), .sw_val_i(sw_val), .mask_o(cpu_mask_i));
initial
begin
    core_clk_i = 0;
    forever #4 core_clk_i = ~core_clk_i;
end
// ========
// Bus, mask-load, compare and report tasks
task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do
    begin
        @(posedge core_clk_i);
        if (s_axi_awready) s_axi_awvalid <= 0;
        if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    wr_resp = s_axi_bresp;
    s_axi_bready <= 0;
endtask
task automatic rd(input logic [7:0] a);
    @(posedge core_clk_i);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do
    begin
        @(posedge core_clk_i);
        if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    rd_d = s_axi_rdata;
    rd_resp = s_axi_rresp;
    s_axi_rready <= 0;
endtask
task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
        fails++;
        $display("mismatch %s expected %h seen %h", s, e, g);
    end
endtask
task automatic setm(input logic [1:0] v);
    @(posedge core_clk_i);
    sw_val <= v;
    sw_set <= 1;
    @(posedge core_clk_i);
    sw_set <= 0;
endtask
task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
        $display("TEST PASSED");
    else
        $display("TEST FAILED");
    $finish;
endtask
// Top edge select frozen while enabled
function automatic logic [7:0] top_exp(logic [7:0] o, logic [7:0] w);
    return {6'h00, o[0] ? o[1] : w[1], w[0]};
endfunction
always @(posedge core_clk_i)
begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
        fails++;
        finish_test();
    end
end
// ========
// Main sequence
initial
begin
    {arst_n_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
    {wait_instr_i, halt_instr_i, watchdog_enabled_i, watchdog_in_halt_option_i} = 0;
    {irq_service_i, nmi_service_i, wake_irq_i, sw_set, sw_val} = 0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
    s_axi_wstrb = 4'hf;
    ext_line_group_i = 4'hf;
    top_level_interrupt_i = 1;
    sw_priority_i = 2'b01;
    void'($urandom(32'h1c23));
    repeat (8) @(posedge core_clk_i);
    arst_n_i <= 1;
    for (int a = 0; a < 12; a += 4)
    begin
        rd(a);
        chk("reset value", 0, rd_d);
    end
    rd(8'h40);
    chk("unmapped resp", `RESP_SLVERR, rd_resp);
    wr(8'h40, 0);
    chk("unmapped wr resp", `RESP_SLVERR, wr_resp);
    $display("test reset done");
    {sense, topv} = 0;
    for (int i = 0; i < 16; i++)
    begin
        m = $urandom_range(3, 0);
        d = $urandom;
        setm(m);
        wr(`OFS_SENSE, d);
        sense = (m == `MASK_LEVEL3) ? d[7:0] : sense;
        rd(`OFS_SENSE);
        chk("sense", sense, rd_d);
        wr(`OFS_TOP, d[15:8]);
        topv = top_exp(topv, d[15:8]);
        rd(`OFS_TOP);
        chk("top ctrl", topv, rd_d);
    end
    $display("test registers done");
    wr(`OFS_TOP, 0);
    wr(`OFS_TOP, 0);
    wr(`OFS_TOP, 1);
    nmi_service_i <= 1;
    @(posedge core_clk_i);
    nmi_service_i <= 0;
    setm(2'b00);
    chk("top idle", 0, top_pending_o);
    top_level_interrupt_i <= 0;
    repeat (8) @(posedge core_clk_i);
    chk("top pending", 1, top_pending_o);
    nmi_service_i <= 1;
    @(posedge core_clk_i);
    nmi_service_i <= 0;
    @(posedge core_clk_i);
    chk("push", 1, mask_push_o);
    top_level_interrupt_i <= 1;
    repeat (8) @(posedge core_clk_i);
    chk("top cleared", 0, top_pending_o);
    chk("mask", 2'b11, cpu_mask_i);
    wr(`OFS_TOP, 0);
    $display("test top done");
    setm(2'b11);
    wr(`OFS_SENSE, 8'h02);
    ext_line_group_i <= 4'he;
    repeat (8) @(posedge core_clk_i);
    chk("pending", 4'h1, ext_pending_o);
    wr(`OFS_SENSE, 8'h03);
    repeat (2) @(posedge core_clk_i);
    chk("pending", 4'h0, ext_pending_o);
    wr(`OFS_SENSE, 8'h00);
    for (int j = 0; j < 2; j++)
    begin
        irq_service_i <= 1;
        @(posedge core_clk_i);
        irq_service_i <= 0;
        ext_line_group_i <= 4'hf;
        repeat (8) @(posedge core_clk_i);
        chk("low level", (j == 0) ? 4'h1 : 4'h0, ext_pending_o);
    end
    $display("test pending done");
    for (int k = 0; k < 5; k++)
    begin
        hc = (k == 1) ? 8'h20 : (k == 2) ? 8'h08 : (k == 3) ? 8'h10 : 8'h00;
        wr(`OFS_CLK, hc);
        watchdog_enabled_i <= (k == 4);
        watchdog_in_halt_option_i <= (k == 4);
        halt_instr_i <= 1;
        @(posedge core_clk_i);
        halt_instr_i <= 0;
        repeat (3) @(posedge core_clk_i);
        chk("halt mode", (k < 2) ? 2 : 0, mode_o);
        if (k < 2)
        begin
            wake_irq_i <= 1;
            while (mode_o != 3'd3) @(posedge core_clk_i);
            for (n = 0; mode_o == 3'd3; n++) @(posedge core_clk_i);
            wake_irq_i <= 0;
            chk("start delay", hc[5] ? 4096 : 256, n);
        end
    end
    {watchdog_enabled_i, watchdog_in_halt_option_i} <= 2'b00;
    $display("test halt done");
    d = $urandom_range(3, 0);
    wr(`OFS_CLK, {d[1:0], 1'b1});
    wait_instr_i <= 1;
    @(posedge core_clk_i);
    wait_instr_i <= 0;
    repeat (3) @(posedge core_clk_i);
    chk("wait mode", 1, mode_o);
    chk("mask", 2'b10, cpu_mask_i);
    n = 0;
    repeat (32) @(posedge core_clk_i) n += periph_clk_en_o;
    chk("slow ticks", 32 >> (d + 1), n);
    wake_irq_i <= 1;
    repeat (4) @(posedge core_clk_i);
    chk("left wait", 0, mode_o == 3'd1);
    $display("test wait done");
    finish_test();
end
endmodule // power_mode_and_ext_wake_ctrl_test
